/* logic/wdtrf_pkg.sv */
// Contract
// [R1] Counter runs from separate 1 MHz oscillator; code instead divides ref_clk by OSC_DIV (10) for a 1 MHz tick
// [R2] Restart, disable or chip reset clears counter
// [R3] Expired enabled counter resets the chip
// [R4] Prescale code picks 16K to 2048K cycles
// [R5] Fuse picks level one or two
// [R6] Level one: enable bit set freely
// [R7] Software unlocks then writes within four cycles
// [R8] Level two: always enabled, reads one
// [R9] Level two: unlock then prescale only
// [R10] Change unlock clears after four cycles
// [R11] Zero enable ignored unless unlocked
// [R12] Prescale changes only while unlocked
// [R13] Debug reset sets bit 4 flag
// [R14] Watchdog reset sets bit 3 flag
// [R15] Supply droop reset sets bit 2 flag
// [R16] Pin reset sets bit 1 flag
// [R17] Power-up sets bit 0, software clears
// [R18] Control bits 7:5 read zero
// [R19] Time-out reset pulse lasts one cycle
// [R20] Locked write only sets enable
package wdtrf_pkg;
	localparam int unsigned REG_W = 8;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned PS_W = 3;
	localparam int unsigned CNT_W = 21;
	localparam int unsigned CAUSE_W = 5;

	localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h60;
	localparam logic [ADDR_W-1:0] CAUSE_ADDR = 8'h54;

	localparam int unsigned CU_BIT = 4;
	localparam int unsigned ON_BIT = 3;
	localparam int unsigned PS_LSB = 0;
	localparam int unsigned DBG_BIT = 4;
	localparam int unsigned TMO_BIT = 3;
	localparam int unsigned DROOP_BIT = 2;
	localparam int unsigned PIN_BIT = 1;
	localparam int unsigned PWR_BIT = 0;

	localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h01;
	localparam logic [REG_W-1:0] READ_IDLE = 8'h00;

	localparam int unsigned SYS_CLK_HZ = 10_000_000;
	localparam int unsigned WDT_OSC_HZ = 1_000_000;
	localparam int unsigned OSC_DIV = SYS_CLK_HZ / WDT_OSC_HZ;
	localparam logic [3:0] OSC_DIV_LAST = 4'(OSC_DIV - 1);
	localparam int unsigned WIN_CYCLES = 4;
	localparam logic [2:0] WIN_LAST = 3'(WIN_CYCLES - 1);
	localparam int unsigned BASE_OSC_CYCLES = 16384;

	typedef enum logic {WIN_CLOSED, WIN_OPEN} wdtrf_win_e;

	// Last count of the selected period, in oscillator ticks
	function automatic logic [CNT_W-1:0] wdtrf_period_last(input logic [PS_W-1:0] sel, input int unsigned base);
		logic [31:0] span;
		span = 32'(base) << sel;
		return CNT_W'(span - 32'h1);
	endfunction
endpackage

/* logic/wdtrf_cnt_if.sv */
`timescale 1ns/10ps
interface wdtrf_cnt_if;
	logic clear;
	logic run;
	logic [2:0] period_sel;
	logic expire;
	modport ctl (output clear, output run, output period_sel, input expire);
	modport cnt (input clear, input run, input period_sel, output expire);
endinterface

/* logic/wdtrf_counter.sv */
`timescale 1ns/10ps
module wdtrf_counter #(
	parameter int unsigned BASE_OSC_CYCLES = wdtrf_pkg::BASE_OSC_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	wdtrf_cnt_if.cnt cnt_bus
);
	import wdtrf_pkg::*;

	logic [3:0] div_reg, div_next;
	logic tick_reg, tick_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic expire_reg, expire_next;

	always_comb begin
		tick_next = (div_reg == OSC_DIV_LAST); // R1
		div_next = tick_next ? 4'h0 : 4'(div_reg + 4'h1);
		cnt_next = cnt_reg;
		expire_next = 1'h0;
		if (cnt_bus.clear || !cnt_bus.run) begin
			cnt_next = '0; // R2
		end else if (tick_reg) begin
			if (cnt_reg == wdtrf_period_last(cnt_bus.period_sel, BASE_OSC_CYCLES)) begin // R4
				expire_next = 1'h1; // R3
				cnt_next = '0;
			end else begin
				cnt_next = CNT_W'(cnt_reg + 1'h1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			div_reg <= 4'h0;
			tick_reg <= 1'h0;
			cnt_reg <= '0;
			expire_reg <= 1'h0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
			cnt_reg <= cnt_next;
			expire_reg <= expire_next;
		end
	end

	assign cnt_bus.expire = expire_reg;
endmodule

/* logic/wdtrf_top.sv */
`timescale 1ns/10ps
module wdtrf_top #(
	parameter int unsigned BASE_OSC_CYCLES = wdtrf_pkg::BASE_OSC_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [wdtrf_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [wdtrf_pkg::REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [wdtrf_pkg::REG_W-1:0] reg_rdata,
	input wire logic restart_instr,
	input wire logic always_on_fuse,
	input wire logic chip_reset_in,
	input wire logic pin_reset_src,
	input wire logic droop_reset_src,
	input wire logic debug_reset_src,
	output logic chip_reset_out,
	output logic watchdog_active
);
	import wdtrf_pkg::*;

	logic on_reg, on_next;
	logic [PS_W-1:0] ps_reg, ps_next;
	wdtrf_win_e win_reg, win_next;
	logic [2:0] wcnt_reg, wcnt_next;
	logic [CAUSE_W-1:0] cause_reg, cause_next;
	logic [REG_W-1:0] rdata_reg, rdata_next;
	logic rst_out_reg, rst_out_next;
	logic active_reg, active_next;

	logic level2;
	logic enabled;
	logic chip_reset;
	logic wr_ctrl;
	logic wr_cause;
	logic unlock_wr;

	wdtrf_cnt_if cnt_bus ();

	wdtrf_counter #(
		.BASE_OSC_CYCLES(BASE_OSC_CYCLES)
	) u_counter (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.cnt_bus(cnt_bus)
	);

	// Fuse high means programmed
	assign level2 = always_on_fuse; // R5
	assign enabled = level2 || on_reg; // R8
	assign chip_reset = chip_reset_in || rst_out_reg;

	assign cnt_bus.run = enabled;
	assign cnt_bus.clear = restart_instr || chip_reset; // R2
	assign cnt_bus.period_sel = ps_reg;

	// Address decode
	always_comb begin
		wr_ctrl = 1'h0;
		wr_cause = 1'h0;
		if (reg_wr && reg_addr == CTRL_ADDR) begin
			wr_ctrl = 1'h1;
		end else if (reg_wr && reg_addr == CAUSE_ADDR) begin
			wr_cause = 1'h1;
		end
	end

	assign unlock_wr = reg_wdata[CU_BIT] && reg_wdata[ON_BIT];

	// Control register and change window
	always_comb begin
		on_next = on_reg;
		ps_next = ps_reg;
		win_next = win_reg;
		wcnt_next = wcnt_reg;
		case (win_reg)
			WIN_OPEN: begin
				if (wcnt_reg == 3'h0) begin
					win_next = WIN_CLOSED; // R10
				end else begin
					wcnt_next = 3'(wcnt_reg - 3'h1);
				end
			end
			default: begin
				wcnt_next = 3'h0;
			end
		endcase
		if (chip_reset) begin
			on_next = CTRL_RESET[ON_BIT];
			ps_next = CTRL_RESET[PS_LSB +: PS_W];
			win_next = WIN_CLOSED;
			wcnt_next = 3'h0;
		end else if (wr_ctrl) begin
			if (unlock_wr) begin
				// Unlock write also enables; window restarts
				on_next = 1'h1;
				win_next = WIN_OPEN; // R7 R9
				wcnt_next = WIN_LAST; // R10
			end else if (!reg_wdata[CU_BIT] && win_reg == WIN_OPEN) begin
				// Enable value is moot at level two
				on_next = reg_wdata[ON_BIT]; // R11 R9
				ps_next = reg_wdata[PS_LSB +: PS_W]; // R12
				win_next = WIN_CLOSED;
				wcnt_next = 3'h0;
			end else if (reg_wdata[ON_BIT]) begin
				on_next = 1'h1; // R6 R20
			end
		end
	end

	// Reset cause flags; a set beats a software clear
	always_comb begin
		cause_next = cause_reg;
		if (wr_cause) begin
			cause_next = cause_reg & reg_wdata[CAUSE_W-1:0]; // R17
		end
		if (debug_reset_src) begin
			cause_next[DBG_BIT] = 1'h1; // R13
		end
		if (cnt_bus.expire) begin
			cause_next[TMO_BIT] = 1'h1; // R14
		end
		if (droop_reset_src) begin
			cause_next[DROOP_BIT] = 1'h1; // R15
		end
		if (pin_reset_src) begin
			cause_next[PIN_BIT] = 1'h1; // R16
		end
	end

	// Read port and outputs
	always_comb begin
		rdata_next = READ_IDLE;
		if (reg_rd && reg_addr == CTRL_ADDR) begin
			rdata_next = READ_IDLE; // R18
			rdata_next[CU_BIT] = (win_reg == WIN_OPEN);
			rdata_next[ON_BIT] = enabled; // R8
			rdata_next[PS_LSB +: PS_W] = ps_reg;
		end else if (reg_rd && reg_addr == CAUSE_ADDR) begin
			rdata_next[CAUSE_W-1:0] = cause_reg;
		end
		rst_out_next = cnt_bus.expire; // R3 R19
		active_next = level2 || on_next;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			on_reg <= CTRL_RESET[ON_BIT];
			ps_reg <= CTRL_RESET[PS_LSB +: PS_W];
			win_reg <= WIN_CLOSED;
			wcnt_reg <= 3'h0;
			cause_reg <= CAUSE_RESET; // R17
			rdata_reg <= READ_IDLE;
			rst_out_reg <= 1'h0;
			active_reg <= 1'h0;
		end else begin
			on_reg <= on_next;
			ps_reg <= ps_next;
			win_reg <= win_next;
			wcnt_reg <= wcnt_next;
			cause_reg <= cause_next;
			rdata_reg <= rdata_next;
			rst_out_reg <= rst_out_next;
			active_reg <= active_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign chip_reset_out = rst_out_reg;
	assign watchdog_active = active_reg;
endmodule

/* testbench/wdtrf_top_properties.sv */
`timescale 1ns/10ps
module wdtrf_top_properties #(
	parameter int unsigned BASE_OSC_CYCLES = 4
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic always_on_fuse,
	input wire logic pin_reset_src,
	input wire logic chip_reset_out,
	input wire logic watchdog_active
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_pulse; chip_reset_out |=> !chip_reset_out; endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
	property p_hi; reg_rd && reg_addr == 8'h60 |=> reg_rdata[7:5] == 3'h0; endproperty
	a_hi: assert property (p_hi) else $error("control upper bits set");
	property p_act; always_on_fuse && $past(always_on_fuse) && $past(resetn) |-> watchdog_active; endproperty
	a_act: assert property (p_act) else $error("level two watchdog off");
	property p_l2rd; always_on_fuse && reg_rd && reg_addr == 8'h60 |=> reg_rdata[3]; endproperty
	a_l2rd: assert property (p_l2rd) else $error("level two enable reads zero");
	property p_win; reg_wr && reg_addr == 8'h60 && reg_wdata[4:3] == 2'h3 ##1 !reg_wr [*4] ##1
		reg_rd && reg_addr == 8'h60 |=> !reg_rdata[4]; endproperty
	a_win: assert property (p_win) else $error("unlock bit not cleared");
	property p_tmo; chip_reset_out ##1 reg_rd && reg_addr == 8'h54 |=> reg_rdata[3]; endproperty
	a_tmo: assert property (p_tmo) else $error("time-out flag missing");
	property p_pin; pin_reset_src ##1 reg_rd && reg_addr == 8'h54 |=> reg_rdata[1]; endproperty
	a_pin: assert property (p_pin) else $error("pin flag missing");
	property p_off; !watchdog_active [*3] |-> !chip_reset_out; endproperty
	a_off: assert property (p_off) else $error("reset while disabled");
endmodule
bind wdtrf_top wdtrf_top_properties #(.BASE_OSC_CYCLES(BASE_OSC_CYCLES)) u_chk (.ref_clk, .resetn, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .always_on_fuse, .pin_reset_src, .chip_reset_out, .watchdog_active);

/* testbench/wdtrf_chip_model.sv */
`timescale 1ns/10ps
module wdtrf_chip_model #(
	parameter int HOLD = 3
) (
	input wire logic ref_clk,
	input wire logic chip_reset_out,
	output logic chip_reset_in
);
	int cnt = 0;
	assign chip_reset_in = cnt != 0;
	// Stretches the time-out pulse into a chip reset
	always @(posedge ref_clk) begin
		if (chip_reset_out) cnt <= HOLD;
		else if (cnt != 0) cnt <= cnt - 1;
	end
endmodule

/* testbench/tb_watchdog_timer_reset_flags.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_watchdog_timer_reset_flags;
	logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, restart_instr = 0, always_on_fuse = 0;
	logic pin_reset_src = 0, droop_reset_src = 0, debug_reset_src = 0, chip_reset_in, chip_reset_out, watchdog_active;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	int mismatches = 0, check_count = 0, n;
	always #50 ref_clk = ~ref_clk;
	wdtrf_top #(.BASE_OSC_CYCLES(4)) DUT (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.restart_instr, .always_on_fuse, .chip_reset_in, .pin_reset_src, .droop_reset_src, .debug_reset_src,
		.chip_reset_out, .watchdog_active);
	wdtrf_chip_model #(.HOLD(3)) u_chip (.ref_clk, .chip_reset_out, .chip_reset_in);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		@(negedge ref_clk);
		`CHK(reg_rdata, e)
	endtask
	task automatic do_reset(input logic fuse);
		@(posedge ref_clk);
		always_on_fuse <= fuse;
		resetn <= 1'h0;
		repeat (4) @(posedge ref_clk);
		resetn <= 1'h1;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic t_flags;
		rd(8'h54, 8'h01);
		rd(8'h60, 8'h00);
		rd(8'h22, 8'h00);
		@(posedge ref_clk);
		{pin_reset_src, droop_reset_src, debug_reset_src} <= 3'h7;
		rd(8'h54, 8'h17);
		@(negedge ref_clk);
		`CHK(reg_rdata, 8'h00)
		@(posedge ref_clk);
		{pin_reset_src, droop_reset_src, debug_reset_src} <= 3'h0;
		wr(8'h54, 8'h00);
		rd(8'h54, 8'h00);
		$display("t_flags done");
	endtask
	task automatic t_level1;
		`CHK(watchdog_active, 1'h0)
		wr(8'h60, 8'h0D);
		rd(8'h60, 8'h08);
		wr(8'h60, 8'h00);
		rd(8'h60, 8'h08);
		wr(8'h60, 8'h18);
		wr(8'h60, 8'h02);
		rd(8'h60, 8'h02);
		$display("t_level1 done");
	endtask
	task automatic t_timeout;
		// Disable must clear the partly run counter
		wr(8'h60, 8'h18);
		wr(8'h60, 8'h08);
		repeat (20) @(posedge ref_clk);
		wr(8'h60, 8'h18);
		wr(8'h60, 8'h00);
		wr(8'h60, 8'h08);
		n = 0;
		while (chip_reset_out !== 1'h1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK(n > 28 && n < 52, 1'h1)
		rd(8'h54, 8'h08);
		wr(8'h54, 8'h00);
		for (int s = 0; s < 8; s++) begin
			wr(8'h60, 8'h18);
			wr(8'h60, {5'h01, 3'(s)});
			// Restart late, so a missed restart shortens the span
			repeat (20 << s) @(posedge ref_clk);
			restart_instr <= 1'h1;
			@(posedge ref_clk);
			restart_instr <= 1'h0;
			n = 0;
			while (chip_reset_out !== 1'h1 && n < 6000) begin
				@(negedge ref_clk);
				n++;
			end
			`CHK(n > (40 << s) - 12 && n < (40 << s) + 12, 1'h1)
			rd(8'h54, 8'h08);
			rd(8'h60, 8'h00);
			wr(8'h54, 8'h00);
		end
		$display("t_timeout done");
	endtask
	task automatic t_level2;
		do_reset(1'h1);
		rd(8'h60, 8'h08);
		`CHK(watchdog_active, 1'h1)
		wr(8'h60, 8'h18);
		wr(8'h60, 8'h03);
		rd(8'h60, 8'h0B);
		wr(8'h60, 8'h18);
		rd(8'h60, 8'h1B);
		wr(8'h60, 8'h18);
		repeat (3) @(posedge ref_clk);
		rd(8'h60, 8'h0B);
		wr(8'h60, 8'h18);
		wr(8'h60, 8'h00);
		rd(8'h60, 8'h08);
		$display("t_level2 done");
	endtask
	initial begin
		do_reset(1'h0);
		t_flags();
		t_level1();
		t_timeout();
		t_level2();
		summarize();
	end
	initial begin
		#3_000_000;
		mismatches++;
		summarize();
	end
endmodule
